// [rtl/psms_sequencer.sv]
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module psms_sequencer (
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire psms_pkg::psms_pins_type pins,
	input  wire psms_pkg::psms_wake_type wake_src,
	input  wire logic                 wdt_reset,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [7:0]                reg_rdata,
	output logic                      battery_power_switch,
	output logic                      field_power_switch,
	output logic                      comparator_en,
	output logic                      core_regulator,
	output logic                      analog_regulator,
	output logic                      core_reset,
	output logic                      cpu_boot,
	output logic                      powerdown_flag,
	output logic                      sleep_flag,
	output logic                      brownout_irq,
	output logic [2:0]                sysclk_div
);

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisers: two flops per pin before any logic
	psms_pkg::psms_pins_type pins_s1_r;
	psms_pkg::psms_pins_type pins_r;
	psms_pkg::psms_wake_type wake_s1_r;
	psms_pkg::psms_wake_type wake_r;
	logic                    wdt_s1_r;
	logic                    wdt_r;

	always_ff @(posedge core_clk)
	begin
		pins_s1_r <= pins;
		pins_r    <= pins_s1_r;
		wake_s1_r <= wake_src;
		wake_r    <= wake_s1_r;
		wdt_s1_r  <= wdt_reset;
		wdt_r     <= wdt_s1_r;
	end

	// reset pin edge history
	logic reset_pin_d_r;
	logic reset_rise;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			reset_pin_d_r <= 1'b1;                                 // idle level high: no false rise
		else
			reset_pin_d_r <= pins_r.reset_pin;
	end

	// rising edge of the released reset pin arms the battery switch
	assign reset_rise = pins_r.reset_pin & ~reset_pin_d_r;

	////////////////////////////////////////////////////////////////////////////////
	// software registers
	// control, wake enable and clock select storage
	logic [7:0] ctrl_r;
	logic [7:0] wake_en_r;
	logic [2:0] clkdiv_r;
	logic       sw_reset;
	logic       auto_sw;

	// control, wake enable and clock select writes; the timer oscillator has no off bit
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ctrl_r    <= psms_pkg::CTRL_RESET;
			wake_en_r <= psms_pkg::WAKE_RESET;
			clkdiv_r  <= psms_pkg::CLKDIV_RESET;
		end
		else if (core_reset)
		begin
			ctrl_r   <= psms_pkg::CTRL_RESET;
			clkdiv_r <= psms_pkg::CLKDIV_RESET;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				psms_pkg::ADDR_CTRL:    ctrl_r    <= reg_wdata;
				psms_pkg::ADDR_WAKE_EN: wake_en_r <= reg_wdata;
				psms_pkg::ADDR_CLKDIV:  clkdiv_r  <= reg_wdata[2:0];
				default:                ;
			endcase
		end
		else
			ctrl_r[psms_pkg::CTRL_SW_RESET] <= 1'b0;              // self-clearing
	end

	// decoded control bits
	assign sw_reset = ctrl_r[psms_pkg::CTRL_SW_RESET];
	assign auto_sw  = ctrl_r[psms_pkg::CTRL_AUTO_SW];

	////////////////////////////////////////////////////////////////////////////////
	// source selection and power switches
	// armed flag and selected source
	logic bat_armed_r;
	logic use_bat;
	logic use_field;
	logic powered;

	// battery switch held open after connect until a pin rise or field arrives
	always_ff @(posedge core_clk)
	begin
		if (rst)
			bat_armed_r <= 1'b0;
		else if (reset_rise || pins_r.field_ok)
			bat_armed_r <= 1'b1;
		else if (ctrl_r[psms_pkg::CTRL_BAT_OFF] && !pins_r.field_ok)
			bat_armed_r <= 1'b0;
	end

	// battery wins when good, field otherwise; forced battery when auto is off
	always_comb
	begin
		use_bat   = 1'b0;
		use_field = 1'b0;
		if (!auto_sw)
			use_bat = bat_armed_r;
		else if (pins_r.bat_ok && bat_armed_r)
			use_bat = 1'b1;
		else if (pins_r.field_ok)
			use_field = 1'b1;
	end

	// any live source keeps the always-on logic running
	assign powered = use_bat | use_field | pins_r.field_ok;

	// switch drives and comparator enable, registered so outputs come from flops
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			battery_power_switch <= 1'b0;
			field_power_switch   <= 1'b0;
			comparator_en        <= 1'b0;
		end
		else
		begin
			battery_power_switch <= use_bat;
			field_power_switch   <= pins_r.field_ok;
			comparator_en        <= auto_sw;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// power state sequencer
	// sequencer state, step counter and wake decodes
	psms_pkg::psms_state_type state_r;
	logic [16:0]              cnt_r;
	logic                     ds_wake;
	logic                     dpd_wake;
	logic                     pin_wake;
	logic [11:0]              wake_low_cnt_r;
	logic                     any_reset;

	// wake pin must stay low long enough before it counts
	always_ff @(posedge core_clk)
	begin
		if (rst || pins_r.wake_pin)
			wake_low_cnt_r <= '0;
		else if (wake_low_cnt_r != 12'(psms_pkg::WAKE_LOW_CYC))
			wake_low_cnt_r <= wake_low_cnt_r + 12'h001;
	end

	// pin wake after the full low time; reset sources combined
	assign pin_wake = (wake_low_cnt_r == 12'(psms_pkg::WAKE_LOW_CYC));
	assign any_reset = ~pins_r.reset_pin | wdt_r | sw_reset;

	// deep sleep wake sources
	assign ds_wake = ~pins_r.reset_pin | wake_r.rtc_event | wake_r.wdt_event | wdt_r
		| pin_wake | (pins_r.field_ok & wake_en_r[psms_pkg::WAKE_RF_EN])
		| wake_r.start_irq;
	// deep power-down wake sources, narrower set
	assign dpd_wake = ~pins_r.reset_pin | wake_r.rtc_event
		| (pin_wake & wake_en_r[psms_pkg::WAKE_PIN_EN])
		| (pins_r.field_ok & wake_en_r[psms_pkg::WAKE_RF_EN]);

	// five modes with staged regulator startup
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_r <= psms_pkg::ST_UNPOWERED;
			cnt_r   <= '0;
		end
		else if (!powered)
		begin
			state_r <= psms_pkg::ST_UNPOWERED;
			cnt_r   <= '0;
		end
		else
		begin
			case (state_r)
				psms_pkg::ST_UNPOWERED:
				begin
					state_r <= psms_pkg::ST_CORE_UP;
					cnt_r   <= '0;
				end
				psms_pkg::ST_CORE_UP:
				begin
					cnt_r <= cnt_r + 17'h00001;
					if (cnt_r >= 17'(psms_pkg::CORE_STEP_CYC) && pins_r.sysosc_ok)
						state_r <= psms_pkg::ST_ANALOG_UP;
				end
				psms_pkg::ST_ANALOG_UP:
				begin
					if (cnt_r < 17'(psms_pkg::STARTUP_CYC))
						cnt_r <= cnt_r + 17'h00001;
					else if (pins_r.flash_ok)
						state_r <= psms_pkg::ST_ACTIVE;
				end
				psms_pkg::ST_ACTIVE:
				begin
					if (ctrl_r[psms_pkg::CTRL_DPD_REQ])
						state_r <= psms_pkg::ST_DEEP_PD;
					else if (ctrl_r[psms_pkg::CTRL_DEEP_REQ])
						state_r <= psms_pkg::ST_DEEP_SLEEP;
					else if (ctrl_r[psms_pkg::CTRL_SLEEP_REQ])
						state_r <= psms_pkg::ST_SLEEP;
				end
				psms_pkg::ST_SLEEP:
				begin
					if (ds_wake || !ctrl_r[psms_pkg::CTRL_SLEEP_REQ])
						state_r <= psms_pkg::ST_ACTIVE;
				end
				psms_pkg::ST_DEEP_SLEEP:
				begin
					if (ds_wake)
						state_r <= psms_pkg::ST_ACTIVE;
				end
				psms_pkg::ST_DEEP_PD:
				begin
					if (dpd_wake)
					begin
						state_r <= psms_pkg::ST_CORE_UP;
						cnt_r   <= '0;
					end
				end
				default: state_r <= psms_pkg::ST_UNPOWERED;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// regulator enables, flags, resets and boot
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			core_regulator   <= 1'b0;
			analog_regulator <= 1'b0;
			powerdown_flag   <= 1'b0;
			sleep_flag       <= 1'b0;
			core_reset       <= 1'b1;
			cpu_boot         <= 1'b0;
		end
		else
		begin
			// independent enables per regulator
			core_regulator   <= (state_r != psms_pkg::ST_UNPOWERED)
				&& (state_r != psms_pkg::ST_DEEP_PD);
			analog_regulator <= (state_r != psms_pkg::ST_UNPOWERED)
				&& (state_r != psms_pkg::ST_DEEP_PD)
				&& (state_r != psms_pkg::ST_CORE_UP);
			powerdown_flag   <= (state_r == psms_pkg::ST_DEEP_PD);
			sleep_flag       <= (state_r == psms_pkg::ST_SLEEP)
				|| (state_r == psms_pkg::ST_DEEP_SLEEP);
			// core reset until regulator on and oscillator stable
			core_reset       <= !(core_regulator && pins_r.sysosc_ok) || any_reset;
			cpu_boot         <= (state_r == psms_pkg::ST_ACTIVE) && pins_r.flash_ok
				&& !any_reset;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// brownout and clock select outputs
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			brownout_irq <= 1'b0;
			sysclk_div   <= psms_pkg::CLKDIV_RESET;
		end
		else
		begin
			brownout_irq <= ctrl_r[psms_pkg::CTRL_BOD_EN] && pins_r.rail_low;
			sysclk_div   <= clkdiv_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read port: data one cycle after the read strobe
	always_ff @(posedge core_clk)
	begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				psms_pkg::ADDR_CTRL:    reg_rdata <= ctrl_r;
				psms_pkg::ADDR_WAKE_EN: reg_rdata <= wake_en_r;
				psms_pkg::ADDR_STATUS:  reg_rdata <= {state_r, use_field, use_bat,
					brownout_irq, powerdown_flag, sleep_flag};
				psms_pkg::ADDR_CLKDIV:  reg_rdata <= {5'h00, clkdiv_r};
				default:                reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

endmodule

// [rtl/psms_pkg.sv]
package psms_pkg;

	// timer oscillator rate and derived timing
	localparam int unsigned CLK_HZ          = 25000000;
	localparam int unsigned STARTUP_US      = 2500;
	localparam int unsigned STARTUP_CYC     = (STARTUP_US * (CLK_HZ / 1000)) / 1000;
	localparam int unsigned CORE_STEP_CYC   = STARTUP_CYC / 4;
	localparam int unsigned WAKE_LOW_US     = 100;
	localparam int unsigned WAKE_LOW_CYC    = (WAKE_LOW_US * (CLK_HZ / 1000) + 999) / 1000;

	// register map
	localparam logic [7:0] ADDR_CTRL        = 8'h00;
	localparam logic [7:0] ADDR_WAKE_EN     = 8'h04;
	localparam logic [7:0] ADDR_STATUS      = 8'h08;
	localparam logic [7:0] ADDR_CLKDIV      = 8'h0c;

	// control register fields
	localparam int unsigned CTRL_AUTO_SW    = 0;
	localparam int unsigned CTRL_BOD_EN     = 1;
	localparam int unsigned CTRL_SLEEP_REQ  = 2;
	localparam int unsigned CTRL_DEEP_REQ   = 3;
	localparam int unsigned CTRL_DPD_REQ    = 4;
	localparam int unsigned CTRL_BAT_OFF    = 5;
	localparam int unsigned CTRL_SW_RESET   = 6;
	localparam logic [7:0]  CTRL_RESET      = 8'h01;

	// wake enable fields
	localparam int unsigned WAKE_PIN_EN     = 0;
	localparam int unsigned WAKE_RF_EN      = 1;
	localparam logic [7:0]  WAKE_RESET      = 8'h00;

	// clock divider select: 0 = 8 MHz ... 7 = 62.5 kHz
	localparam logic [2:0]  CLKDIV_RESET    = 3'h4;

	typedef enum logic [2:0] {
		ST_UNPOWERED,
		ST_CORE_UP,
		ST_ANALOG_UP,
		ST_ACTIVE,
		ST_SLEEP,
		ST_DEEP_SLEEP,
		ST_DEEP_PD
	} psms_state_type;

	typedef struct packed {
		logic bat_ok;
		logic field_ok;
		logic reset_pin;
		logic wake_pin;
		logic rail_low;
		logic sysosc_ok;
		logic flash_ok;
	} psms_pins_type;

	typedef struct packed {
		logic rtc_event;
		logic wdt_event;
		logic start_irq;
	} psms_wake_type;

endpackage

// [verif/psms_chk.sv]
`timescale 1ns/10ps
module psms_chk (
	input	wire logic			core_clk,
	input	wire logic			rst,
	input	wire psms_pkg::psms_pins_type	pins,
	input	wire psms_pkg::psms_wake_type	wake_src,
	input	wire logic			wdt_reset,
	input	wire logic [7:0]		reg_addr,
	input	wire logic [7:0]		reg_wdata,
	input	wire logic			reg_wr,
	input	wire logic			reg_rd,
	input	wire logic [7:0]		reg_rdata,
	input	wire logic			battery_power_switch,
	input	wire logic			field_power_switch,
	input	wire logic			comparator_en,
	input	wire logic			core_regulator,
	input	wire logic			analog_regulator,
	input	wire logic			core_reset,
	input	wire logic			cpu_boot,
	input	wire logic			powerdown_flag,
	input	wire logic			sleep_flag,
	input	wire logic			brownout_irq,
	input	wire logic [2:0]		sysclk_div
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	// power state relations
	rst_vals_a: assert property (
		disable iff (1'b0) rst |=> core_reset && sysclk_div == psms_pkg::CLKDIV_RESET && !cpu_boot)
		else $error("bad values after reset");
	fsw_follow_a: assert property (
		$rose(pins.field_ok) |-> ##[1:5] field_power_switch)
		else $error("field switch late");
	boot_gate_a: assert property (
		cpu_boot |-> !core_reset && core_regulator && analog_regulator)
		else $error("boot without power");
	dpd_off_a: assert property (
		powerdown_flag |-> !core_regulator && !analog_regulator && !sleep_flag)
		else $error("regulator on in powerdown");
	sleep_on_a: assert property (
		sleep_flag |-> core_regulator && analog_regulator)
		else $error("regulator off in sleep");
	core_first_a: assert property (
		$rose(analog_regulator) |-> core_regulator)
		else $error("analog before core");
	por_core_a: assert property (
		$fell(core_reset) |-> core_regulator && pins.sysosc_ok)
		else $error("core reset released early");
	bod_cause_a: assert property (
		!pins.rail_low [*6] |-> !brownout_irq)
		else $error("brownout without droop");
	bat_need_a: assert property (
		!pins.bat_ok [*6] ##0 comparator_en |-> !battery_power_switch)
		else $error("battery switch without battery");
	rd_idle_a: assert property (
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	// main scenarios
	cover property ($rose(cpu_boot));
	cover property ($rose(powerdown_flag));
	cover property ($rose(brownout_irq));
	cover property ($fell(sleep_flag));
endmodule
bind psms_sequencer psms_chk psms_chk_i (.*);

// [verif/psms_supply.sv]
`timescale 1ns/10ps
module psms_supply (
	input	wire logic			core_clk,
	input	wire logic			bat_on,
	input	wire logic			field_on,
	input	wire logic			pin_low,
	input	wire logic			droop,
	input	wire logic			wake_low,
	input	wire logic			core_regulator,
	input	wire logic			analog_regulator,
	output	psms_pkg::psms_pins_type	pins
);
	int osc_cnt = 0;
	int fl_cnt = 0;
	////////////////////////////////////////////////////////////////
	// oscillator and flash settle a while after their regulator
	always_ff @(posedge core_clk)
	begin
		osc_cnt <= core_regulator ? osc_cnt + 1 : 0;
		fl_cnt <= analog_regulator ? fl_cnt + 1 : 0;
	end
	// pin levels; reset and wake pins have pull-ups
	always_ff @(posedge core_clk)
	begin
		pins.bat_ok <= bat_on;
		pins.field_ok <= field_on;
		pins.reset_pin <= !pin_low;
		pins.wake_pin <= !wake_low;
		pins.rail_low <= droop;
		pins.sysosc_ok <= osc_cnt > 40;
		pins.flash_ok <= fl_cnt > 40;
	end
endmodule

// [verif/psms_sequencer_bench.sv]
`timescale 1ns/10ps
module psms_sequencer_bench;
	logic core_clk, rst, reg_wr, reg_rd, bat_on, field_on, pin_low, droop, wake_low, wdt;
	logic [2:0] wsrc, sysclk_div;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic bsw, fsw, cmp, creg, areg, crst, boot, pdf, slf, brownout_detector;
	psms_pkg::psms_pins_type pins;
	int n_mismatch, checks, i, t;
	logic [15:0] rows [5] = '{16'h0001, 16'h0400, 16'h0800, 16'h0c04, 16'h1000};
	psms_sequencer psms_sequencer_i (.core_clk(core_clk), .rst(rst), .pins(pins),
		.wake_src(wsrc), .wdt_reset(wdt), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.battery_power_switch(bsw), .field_power_switch(fsw), .comparator_en(cmp),
		.core_regulator(creg), .analog_regulator(areg), .core_reset(crst),
		.cpu_boot(boot), .powerdown_flag(pdf), .sleep_flag(slf),
		.brownout_irq(brownout_detector), .sysclk_div(sysclk_div));
	psms_supply psms_supply_i (.core_clk(core_clk), .bat_on(bat_on), .field_on(field_on),
		.pin_low(pin_low), .droop(droop), .wake_low(wake_low), .core_regulator(creg),
		.analog_regulator(areg), .pins(pins));
	////////////////////////////////////////////////////////////////
	// clock
	always #20 core_clk = ~core_clk;
	// helpers
	task automatic test_done();
		if (n_mismatch == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		chk8({7'h00, g}, {7'h00, e});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		cyc(1);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		cyc(1);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		cyc(1);
		reg_rd <= 1'b1;
		reg_addr <= a;
		cyc(1);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	////////////////////////////////////////////////////////////////
	// watchdog
	initial
	begin
		#3200000;
		n_mismatch++;
		test_done();
	end
	// main sequence
	initial
	begin
		{core_clk, reg_wr, reg_rd, bat_on, field_on, pin_low, droop, wake_low, wdt} = '0;
		{wsrc, reg_addr, reg_wdata, n_mismatch, checks} = '0;
		rst = 1'b1;
		cyc(4);
		rst <= 1'b0;
		chk1(crst, 1'b1);
		chk1(boot, 1'b0);
		for (i = 0; i < 5; i++)
		begin
			rd(rows[i][15:8]);
			chk8(d, rows[i][7:0]);
		end
		cyc(1);
		bat_on <= 1'b1;
		cyc(20);
		chk1(bsw, 1'b0);
		wr(psms_pkg::ADDR_CLKDIV, 8'h07);
		pin_low <= 1'b1;
		cyc(5);
		pin_low <= 1'b0;
		cyc(10);
		chk1(bsw, 1'b1);
		for (t = 10; boot !== 1'b1 && t < 70000; t++)
			cyc(1);
		chk1(t > psms_pkg::STARTUP_CYC - 500 && t < psms_pkg::STARTUP_CYC + 500, 1'b1);
		rd(psms_pkg::ADDR_CLKDIV);
		chk8(d, 8'h04);
		rd(psms_pkg::ADDR_STATUS);
		chk8(d, 8'h68);
		chk1(areg, 1'b1);
		for (i = 0; i < 8; i++)
		begin
			wr(psms_pkg::ADDR_CLKDIV, i[7:0]);
			cyc(2);
			chk8({5'h00, sysclk_div}, i[7:0]);
		end
		field_on <= 1'b1;
		cyc(8);
		chk1(fsw, 1'b1);
		chk1(bsw, 1'b1);
		bat_on <= 1'b0;
		cyc(8);
		chk1(bsw, 1'b0);
		chk1(boot, 1'b1);
		rd(psms_pkg::ADDR_STATUS);
		chk8(d, 8'h70);
		bat_on <= 1'b1;
		cyc(8);
		chk1(bsw, 1'b1);
		wr(psms_pkg::ADDR_CTRL, 8'h00);
		cyc(2);
		chk1(cmp, 1'b0);
		chk1(bsw, 1'b1);
		wr(psms_pkg::ADDR_CTRL, 8'h03);
		droop <= 1'b1;
		cyc(8);
		chk1(brownout_detector, 1'b1);
		wr(psms_pkg::ADDR_CTRL, 8'h01);
		cyc(2);
		chk1(brownout_detector, 1'b0);
		droop <= 1'b0;
		wr(psms_pkg::ADDR_CTRL, 8'h05);
		cyc(4);
		chk1(slf, 1'b1);
		wr(psms_pkg::ADDR_CTRL, 8'h01);
		cyc(4);
		chk1(slf, 1'b0);
		for (i = 0; i < 3; i++)
		begin
			wr(psms_pkg::ADDR_CTRL, 8'h09);
			cyc(4);
			chk1(slf, 1'b1);
			wr(psms_pkg::ADDR_CTRL, 8'h01);
			cyc(4);
			chk1(slf, 1'b1);
			wsrc <= 3'h4 >> i;
			cyc(6);
			chk1(slf, 1'b0);
			wsrc <= 3'h0;
		end
		// wake pin: still asleep 200 cycles into the low, the full low time wakes
		wr(psms_pkg::ADDR_CTRL, 8'h09);
		wr(psms_pkg::ADDR_CTRL, 8'h01);
		wake_low <= 1'b1;
		cyc(200);
		chk1(slf, 1'b1);
		cyc(2500);
		chk1(slf, 1'b0);
		wake_low <= 1'b0;
		// watchdog and software reset sources
		wdt <= 1'b1;
		cyc(6);
		chk1(crst, 1'b1);
		chk1(boot, 1'b0);
		wdt <= 1'b0;
		cyc(6);
		chk1(crst, 1'b0);
		chk1(boot, 1'b1);
		chk8({5'h00, sysclk_div}, {5'h00, psms_pkg::CLKDIV_RESET});
		wr(psms_pkg::ADDR_CTRL, 8'h41);
		cyc(2);
		chk1(crst, 1'b1);
		cyc(3);
		chk1(crst, 1'b0);
		field_on <= 1'b0;
		wr(psms_pkg::ADDR_WAKE_EN, 8'h02);
		wr(psms_pkg::ADDR_CTRL, 8'h11);
		cyc(6);
		chk1(pdf, 1'b1);
		chk1(creg, 1'b0);
		chk1(areg, 1'b0);
		wsrc <= 3'h1;
		cyc(8);
		chk1(pdf, 1'b1);
		wsrc <= 3'h0;
		field_on <= 1'b1;
		cyc(10);
		chk1(pdf, 1'b0);
		chk1(creg, 1'b1);
		// battery off without field turns the device off
		field_on <= 1'b0;
		cyc(60);
		wr(psms_pkg::ADDR_CTRL, 8'h21);
		cyc(6);
		chk1(bsw, 1'b0);
		chk1(creg, 1'b0);
		test_done();
	end
endmodule
